/* design/pbs_pkg.sv */
package pbs_pkg;

   // Geometry of the word: four lanes of eight data bits plus one parity bit.
   localparam int LANES = 4;
   localparam int LANE_DATA_W = 8;
   localparam int LANE_W = 9;
   localparam int WORD_W = 36;
   localparam int DQ_W = 32;
   localparam int BURST_W = 2;

   // Register offsets, byte addresses on the APB bus.
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_LAST_ADDR = 12'h008;

   // Control register fields.
   localparam int CTRL_INHIBIT_BIT = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // Status register fields.
   localparam int STAT_ACTIVE_BIT = 0;
   localparam int STAT_INTERLEAVED_BIT = 1;
   localparam int STAT_CNT_LSB = 2;
   localparam int STAT_VALID_BIT = 4;
   localparam int STAT_WRITE_BIT = 5;

   // Reset value of the burst-order setting: interleaved, as for a floating strap.
   localparam logic MODE_RESET = 1'b1;

   // Synchronous control pins of the memory, sampled on the rising clock edge.
   typedef struct packed {
      logic proc_addr_strobe_n;
      logic ctrl_addr_strobe_n;
      logic burst_advance_n;
      logic global_write_n;
      logic byte_write_en_n;
      logic [LANES-1:0] byte_lane_sel_n;
      logic chip_sel_a_n;
      logic chip_sel_b;
      logic chip_sel_c_n;
   } pbs_ctl_t;

   typedef enum logic [1:0] {
      PBS_DESEL,
      PBS_OPEN,
      PBS_BURST
   } pbs_state_t;

endpackage

/* design/pbs_sram.sv */
// Local design decisions: the address map and the APB slave port.
module pbs_sram
   import pbs_pkg::*;
#(
   parameter int ADDR_W = 20
) (
   // APB clock and reset; the memory clock is the same clock.
   input wire logic pclk,
   input wire logic presetn,
   // APB register port.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Memory address and control pins.
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire pbs_ctl_t mem_ctl,
   input wire logic output_en_n,
   input wire logic burst_order_strap,
   // Data and parity pins, split into input, output and enable.
   input wire logic [DQ_W-1:0] dq_in,
   output logic [DQ_W-1:0] dq_out,
   output logic dq_oe,
   input wire logic [LANES-1:0] parity_io_in,
   output logic [LANES-1:0] parity_io_out,
   output logic parity_io_oe
);

   // The array has no reset: a memory keeps no defined contents at power-up.
   logic [WORD_W-1:0] mem_array [0:(2**ADDR_W)-1];

   // Registered state.
   pbs_state_t state;
   logic [2:0] strap_sync;
   logic interleaved;
   logic [ADDR_W-3:0] addr_hi;
   logic [BURST_W-1:0] burst_start;
   logic [BURST_W-1:0] burst_cnt;
   logic [ADDR_W-1:0] rd_addr;
   logic rd_pend;
   logic [WORD_W-1:0] dout;
   logic dout_valid;
   logic wr_seen;
   logic [31:0] ctrl_reg;
   logic [ADDR_W-1:0] last_addr;

   // Decode of the current edge.
   logic ps_seen;
   logic cs_seen;
   logic strobe;
   logic enables_ok;
   logic load;
   logic desel;
   logic carry_on;
   logic wr_ctl;
   logic [LANES-1:0] wr_mask;
   logic [BURST_W-1:0] next_cnt;
   logic [ADDR_W-1:0] acc_addr;
   logic do_write;
   logic do_read;
   logic [WORD_W-1:0] din_word;
   logic apb_access;

   // Address bits of the burst for a given start and step.
   function automatic logic [BURST_W-1:0] burst_bits(input logic [BURST_W-1:0] start,
                                                     input logic [BURST_W-1:0] cnt,
                                                     input logic ilv);
      if (ilv) begin
         burst_bits = start ^ cnt;
      end else begin
         burst_bits = start + cnt;
      end
   endfunction

   // Lanes to store: global write covers every lane, otherwise byte enable with selects.
   function automatic logic [LANES-1:0] lane_mask(input pbs_ctl_t c);
      if (!c.global_write_n) begin
         lane_mask = {LANES{1'b1}};
      end else if (!c.byte_write_en_n) begin
         lane_mask = ~c.byte_lane_sel_n;
      end else begin
         lane_mask = '0;
      end
   endfunction

   // Status fields are placed by the package constants; unused bits read as zero.
   function automatic logic [31:0] status_word(input logic active,
                                               input logic ilv,
                                               input logic [BURST_W-1:0] cnt,
                                               input logic valid,
                                               input logic wr);
      status_word = 32'h0;
      status_word[STAT_ACTIVE_BIT] = active;
      status_word[STAT_INTERLEAVED_BIT] = ilv;
      status_word[STAT_CNT_LSB +: BURST_W] = cnt;
      status_word[STAT_VALID_BIT] = valid;
      status_word[STAT_WRITE_BIT] = wr;
   endfunction

   // The strap is a static pin, yet it is filtered so a bounce cannot flip the order mid-burst.
   // Reset fills the filter with the reset order, so no false order change follows reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_sync <= {3{MODE_RESET}};
      end else begin
         strap_sync <= {strap_sync[1:0], burst_order_strap};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interleaved <= MODE_RESET;
      end else if (strap_sync[1] == strap_sync[2]) begin
         interleaved <= strap_sync[2];
      end
   end

   // Address strobe decode.
   always_comb begin
      ps_seen = !mem_ctl.proc_addr_strobe_n && !mem_ctl.chip_sel_a_n;
      cs_seen = !mem_ctl.ctrl_addr_strobe_n && !ps_seen;
      strobe = ps_seen || cs_seen;
   end

   // Chip enables only matter on an edge with an address strobe, which they turn into a load or a deselect;
   // chip_sel_a_n high drops a processor strobe altogether, and a continuing burst ignores them.
   always_comb begin
      enables_ok = !mem_ctl.chip_sel_a_n && mem_ctl.chip_sel_b && !mem_ctl.chip_sel_c_n;
      load = strobe && enables_ok;
      desel = strobe && !enables_ok;
      carry_on = (state != PBS_DESEL) && !strobe;
   end

   // Write qualification from the global and byte controls.
   always_comb begin
      wr_mask = lane_mask(mem_ctl);
      wr_ctl = |wr_mask;
   end

   // The stepped count is used at once, so a write at an advancing edge lands on the next address.
   always_comb begin
      if (carry_on && !mem_ctl.burst_advance_n) begin
         next_cnt = burst_cnt + 2'h1;
      end else begin
         next_cnt = burst_cnt;
      end
   end

   always_comb begin
      if (load) begin
         acc_addr = mem_addr;
      end else begin
         acc_addr = {addr_hi, burst_bits(burst_start, next_cnt, interleaved)};
      end
   end

   // Operation of this edge: a write or a read, never both.
   always_comb begin
      do_write = (cs_seen && load && wr_ctl) || (carry_on && wr_ctl);
      do_read = (load && !do_write) || (carry_on && !wr_ctl);
   end

   generate
      for (genvar i = 0; i < LANES; i++) begin : g_lane
         assign din_word[i*LANE_W +: LANE_W] = {parity_io_in[i], dq_in[i*LANE_DATA_W +: LANE_DATA_W]};
         // Parity rides in the top bit of each nine-bit lane.
         assign dq_out[i*LANE_DATA_W +: LANE_DATA_W] = dout[i*LANE_W +: LANE_DATA_W];
         assign parity_io_out[i] = dout[i*LANE_W + LANE_DATA_W];
      end
   endgenerate

   // One process stores the lanes, so the array has a single writer; unselected lanes keep their contents.
   always_ff @(posedge pclk) begin
      if (do_write) begin
         for (int i = 0; i < LANES; i++) begin
            if (wr_mask[i]) begin
               mem_array[acc_addr][i*LANE_W +: LANE_W] <= din_word[i*LANE_W +: LANE_W];
            end
         end
      end
   end

   // The open state marks the first cycle of an access that starts from deselect, during which the drivers stay off.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= PBS_DESEL;
      end else begin
         case (state)
            PBS_DESEL: begin
               if (load) begin
                  state <= PBS_OPEN;
               end
            end
            PBS_OPEN,
            PBS_BURST: begin
               if (desel) begin
                  state <= PBS_DESEL;
               end else begin
                  state <= PBS_BURST;
               end
            end
            default: begin
               state <= PBS_DESEL;
            end
         endcase
      end
   end

   // Seed on strobe
   // The upper address bits are held for the whole burst; only the two low bits move.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_hi <= '0;
         burst_start <= '0;
      end else if (load) begin
         addr_hi <= mem_addr[ADDR_W-1:BURST_W];
         burst_start <= mem_addr[BURST_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         burst_cnt <= '0;
      end else if (load) begin
         burst_cnt <= '0;
      end else if (carry_on) begin
         burst_cnt <= next_cnt;
      end
   end

   // Pipelined read
   // The address is registered with the read, so the array is read one edge later for the output register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_pend <= 1'b0;
         rd_addr <= '0;
      end else begin
         rd_pend <= do_read;
         rd_addr <= acc_addr;
      end
   end

   // A write edge is remembered for one cycle so the drivers stay off while the bus turns around.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_seen <= 1'b0;
      end else begin
         wr_seen <= do_write;
      end
   end

   // Last array address, kept for software; a deselect or an idle edge leaves it alone.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_addr <= '0;
      end else if (load || carry_on) begin
         last_addr <= acc_addr;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dout <= '0;
      end else if (rd_pend) begin
         dout <= mem_array[rd_addr];
      end
   end

   // A deselect edge clears the valid flag at once, so the drivers let go without waiting for the pipe.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dout_valid <= 1'b0;
      end else begin
         dout_valid <= rd_pend && !desel;
      end
   end

   // Output enable is asynchronous at the pin, so it gates the drivers without a register.
   always_comb begin
      dq_oe = 1'b0;
      if (dout_valid && !wr_seen && (state != PBS_OPEN)) begin
         dq_oe = !output_en_n && !ctrl_reg[CTRL_INHIBIT_BIT];
      end
      parity_io_oe = dq_oe;
   end

   // APB slave: zero wait states, unmapped offsets answer with an error and zero data.
   assign pready = 1'b1;
   assign apb_access = psel && penable;

   // Only the inhibit bit is stored; the other control bits read back as zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= CTRL_RESET;
      end else if (apb_access && pwrite && paddr == OFS_CTRL) begin
         ctrl_reg <= {31'h0, pwdata[CTRL_INHIBIT_BIT]};
      end
   end

   always_comb begin
      prdata = 32'h0;
      pslverr = 1'b0;
      if (apb_access) begin
         case (paddr)
            OFS_CTRL: begin
               prdata = ctrl_reg;
            end
            OFS_STATUS: begin
               prdata = status_word(state != PBS_DESEL, interleaved, burst_cnt, dout_valid, wr_seen);
            end
            OFS_LAST_ADDR: begin
               prdata[ADDR_W-1:0] = last_addr;
            end
            default: begin
               pslverr = 1'b1;
            end
         endcase
      end
   end

endmodule

/* verif/pbs_sram_props.sv */
module pbs_sram_props
   import pbs_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Memory pins.
   input wire pbs_ctl_t mem_ctl,
   input wire logic output_en_n,
   input wire logic dq_oe,
   input wire logic parity_io_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic en;
   assign en = !mem_ctl.chip_sel_a_n && mem_ctl.chip_sel_b && !mem_ctl.chip_sel_c_n;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence ctrl_s;
      !mem_ctl.ctrl_addr_strobe_n && mem_ctl.proc_addr_strobe_n && en;
   endsequence
   sequence open_s;
      !mem_ctl.proc_addr_strobe_n && en;
   endsequence
   sequence desel_s;
      !mem_ctl.ctrl_addr_strobe_n && !en;
   endsequence
   sequence rd_s;
      en && (!mem_ctl.proc_addr_strobe_n || (!mem_ctl.ctrl_addr_strobe_n && mem_ctl.global_write_n));
   endsequence
   oe_gate_a: assert property (output_en_n |-> !dq_oe)
      else $error("data driven with output enable off");
   lane_oe_a: assert property (parity_io_oe == dq_oe)
      else $error("parity enable differs from data enable");
   gw_float_a: assert property (ctrl_s ##0 !mem_ctl.global_write_n |=> !dq_oe)
      else $error("bus driven after global write");
   byte_float_a: assert property (ctrl_s ##0 (mem_ctl.global_write_n && !mem_ctl.byte_write_en_n) |=> !dq_oe)
      else $error("bus driven after byte write");
   pwrite_float_a: assert property (open_s ##1 (mem_ctl.proc_addr_strobe_n && !mem_ctl.global_write_n) |=> !dq_oe)
      else $error("bus driven after second write edge");
   desel_b_a: assert property (!mem_ctl.ctrl_addr_strobe_n && !mem_ctl.chip_sel_b |=> !dq_oe)
      else $error("bus driven after deselect");
   desel_a_a: assert property (!mem_ctl.ctrl_addr_strobe_n && mem_ctl.chip_sel_a_n |=> !dq_oe)
      else $error("first enable polarity wrong");
   first_mask_a: assert property (desel_s ##1 rd_s |=> !dq_oe)
      else $error("bus driven in first cycle after deselect");
endmodule

/* verif/pbs_bus_model.sv */
module pbs_bus_model
   import pbs_pkg::*;
(
   // Clock.
   input wire logic pclk,
   // Address and controls.
   output logic [7:0] mem_addr,
   output pbs_ctl_t mem_ctl,
   output logic output_en_n,
   output logic burst_order_strap,
   // Write data.
   output logic [DQ_W-1:0] dq_in,
   output logic [LANES-1:0] parity_io_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic oe_off = 1'b0;
   initial begin
      mem_addr = 8'h00;
      mem_ctl = 12'hffa;
      output_en_n = 1'b0;
      burst_order_strap = 1'b1;
      {parity_io_in, dq_in} = 36'h0;
   end
   task automatic set_strap(input logic s);
      burst_order_strap <= s;
   endtask
   task automatic cyc(input logic [7:0] a, input pbs_ctl_t c, input logic [35:0] d);
      logic wr;
      wr = !c.global_write_n || !c.byte_write_en_n;
      @(posedge pclk);
      mem_addr <= a;
      mem_ctl <= c;
      output_en_n <= wr || oe_off;
      // Idle data is inverted so a stale value never passes for a real one.
      {parity_io_in, dq_in} <= wr ? d : ~{parity_io_in, dq_in};
   endtask
endmodule

/* verif/pipelined_burst_sram_access_tb.sv */
module pipelined_burst_sram_access_tb
   import pbs_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic pr;
      logic [7:0] a;
      logic [3:0] w;
      logic [35:0] d;
      logic [35:0] x;
   } pbs_row_t;
   localparam pbs_ctl_t IDLE = 12'hffa;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dq_oe, parity_io_oe, output_en_n, burst_order_strap;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, dq_in, dq_out, r;
   logic [3:0] parity_io_in, parity_io_out;
   logic [7:0] mem_addr;
   logic e;
   pbs_ctl_t mem_ctl, c;
   int fails = 0;
   int checks_done = 0;
   // Row w is the active-low lane select of a byte write; 4'h0 selects a global write instead.
   pbs_row_t rows [4] = '{'{0, 8'h10, 4'h0, 36'ha_1122_3344, 36'ha_1122_3344},
      '{0, 8'h10, 4'ha, 36'h5_5566_7788, 36'hf_1166_3388}, '{1, 8'h12, 4'h0, 36'h0_dead_beef, 36'h0_dead_beef},
      '{1, 8'h12, 4'h7, 36'h8_aa00_0000, 36'h8_aaad_beef}};
   logic [11:0] dm [3] = '{12'h402, 12'h404, 12'h401};
   pbs_sram #(.ADDR_W(8)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mem_addr(mem_addr), .mem_ctl(mem_ctl), .output_en_n(output_en_n), .burst_order_strap(burst_order_strap),
      .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .parity_io_in(parity_io_in),
      .parity_io_out(parity_io_out), .parity_io_oe(parity_io_oe));
   pbs_bus_model u_bus (.pclk(pclk), .mem_addr(mem_addr), .mem_ctl(mem_ctl), .output_en_n(output_en_n),
      .burst_order_strap(burst_order_strap), .dq_in(dq_in), .parity_io_in(parity_io_in));
   task automatic chk(input logic [36:0] got, input logic [36:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [35:0] x);
      pbs_ctl_t b;
      b = IDLE;
      b.ctrl_addr_strobe_n = 1'b0;
      u_bus.cyc(a, b, 36'h0);
      u_bus.cyc(a, IDLE, 36'h0);
      @(posedge pclk);
      #1;
      chk({parity_io_out, dq_out}, x);
      chk(dq_oe, 1'b1);
   endtask
   task automatic burst(input logic [3:0][1:0] s);
      pbs_ctl_t b;
      b = IDLE;
      b.proc_addr_strobe_n = 1'b0;
      u_bus.cyc(8'h21, b, 36'h0);
      b = IDLE;
      b.burst_advance_n = 1'b0;
      u_bus.cyc(8'h21, b, 36'h0);
      for (int k = 0; k < 4; k++) begin
         b.burst_advance_n = (k != 0);
         u_bus.cyc(8'h21, b, 36'h0);
         #1;
         chk({parity_io_out, dq_out}, 36'h1_0101_0101 * (36'(s[3-k]) + 36'h1));
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      #100000;
      fails++;
      report_and_stop();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         c = IDLE;
         if (rows[i].pr) begin
            c.proc_addr_strobe_n = 1'b0;
            c.global_write_n = 1'b0;
            u_bus.cyc(rows[i].a, c, ~rows[i].d);
            c = IDLE;
         end else begin
            c.ctrl_addr_strobe_n = 1'b0;
         end
         c.global_write_n = rows[i].w != 4'h0;
         c.byte_write_en_n = rows[i].w == 4'h0;
         c.byte_lane_sel_n = rows[i].w;
         u_bus.cyc(rows[i].a, c, rows[i].d);
         rd(rows[i].a, rows[i].x);
      end
      c = IDLE;
      c.ctrl_addr_strobe_n = 1'b0;
      u_bus.cyc(8'h10, c, 36'h0);
      u_bus.cyc(8'h12, c, 36'h0);
      u_bus.cyc(8'h12, IDLE, 36'h0);
      #1 chk({parity_io_out, dq_out}, 36'hf_1166_3388);
      u_bus.cyc(8'h12, IDLE, 36'h0);
      #1 chk({parity_io_out, dq_out}, 36'h8_aaad_beef);
      c.global_write_n = 1'b0;
      for (int i = 0; i < 4; i++) u_bus.cyc(8'h20 + 8'(i), c, 36'h1_0101_0101 * 36'(i + 1));
      burst({2'd1, 2'd0, 2'd3, 2'd3});
      foreach (dm[i]) begin
         u_bus.cyc(8'h10, IDLE ^ dm[i], 36'h0);
         u_bus.cyc(8'h10, c ^ 12'h100, 36'h0);
         #1 chk(dq_oe, 1'b0);
         u_bus.cyc(8'h10, IDLE, 36'h0);
         #1 chk(dq_oe, 1'b0);
         u_bus.cyc(8'h10, IDLE, 36'h0);
         #1 chk({dq_oe, parity_io_out, dq_out}, 37'h1_f_1166_3388);
      end
      u_bus.oe_off = 1'b1;
      u_bus.cyc(8'h10, IDLE, 36'h0);
      #1 chk(dq_oe, 1'b0);
      u_bus.oe_off = 1'b0;
      apb(1'b1, OFS_CTRL, 32'h1);
      u_bus.cyc(8'h10, IDLE, 36'h0);
      #1 chk(dq_oe, 1'b0);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(r, 32'h1);
      apb(1'b0, 12'h00c, 32'h0);
      chk({e, r}, 33'h1_0000_0000);
      apb(1'b1, OFS_CTRL, 32'h0);
      @(posedge pclk);
      presetn <= 1'b0;
      u_bus.set_strap(1'b0);
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      #1 chk(dq_oe, 1'b0);
      // The strap filter needs a few edges to take up the new order.
      repeat (4) @(posedge pclk);
      burst({2'd1, 2'd2, 2'd3, 2'd3});
      report_and_stop();
   end
endmodule
bind pbs_sram pbs_sram_props u_props (.pclk(pclk), .presetn(presetn), .mem_ctl(mem_ctl),
   .output_en_n(output_en_n), .dq_oe(dq_oe), .parity_io_oe(parity_io_oe));
